// [design/ofm_defines.svh]
/*
  Constants of the oscillation frequency monitor: register byte addresses,
  write key and enable codes, limit reset values and measurement figures.
  Assumes it is included by bare name after the package that holds the types.
*/
`ifndef OFM_DEFINES_SVH
`define OFM_DEFINES_SVH

// ------------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------------
`define OFM_ADDR_WRITE_KEY     32'h4004_0800
`define OFM_ADDR_ENABLE_CODE   32'h4004_0804
`define OFM_ADDR_LOWER_OFF     32'h4004_0808
`define OFM_ADDR_LOWER_ON      32'h4004_080C
`define OFM_ADDR_UPPER_OFF     32'h4004_0810
`define OFM_ADDR_UPPER_ON      32'h4004_0814
`define OFM_ADDR_STATUS        32'h4004_0818

// ------------------------------------------------------------------
// Codes and reset values
// ------------------------------------------------------------------
`define OFM_KEY_UNLOCK         8'hF9
`define OFM_KEY_LOCK           8'h06
`define OFM_CODE_ENABLE        8'hE4
`define OFM_CODE_DISABLE       8'h00
`define OFM_LIMIT_W            9
`define OFM_RST_LOWER_OFF      9'h010
`define OFM_RST_LOWER_ON       9'h0D1
`define OFM_RST_UPPER_OFF      9'h028
`define OFM_RST_UPPER_ON       9'h139

// ------------------------------------------------------------------
// Measurement figures
// ------------------------------------------------------------------
`define OFM_REF_WINDOW         128
`define OFM_TARGET_DIV         4
`define OFM_PERSIST_WINDOWS    4
`define OFM_STATUS_FAULT_BIT   0
`define OFM_STATUS_ACTIVE_BIT  1
`define OFM_STATUS_LOW_BIT     2
`define OFM_STATUS_HIGH_BIT    3
`define OFM_STATUS_COUNT_LSB   8

`endif

// [design/ofm_pkg.sv]
/*
  Types of the oscillation frequency monitor: bus request carrier, measurement
  result carrier and persistence states.
  Assumes nothing of its surroundings.
*/
package ofm_pkg;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ofm_bus_req_t;

  typedef struct packed {
    logic       done;
    logic [8:0] count;
  } ofm_meas_t;

  // ------------------------------------------------------------------
  // Persistence filter states
  // ------------------------------------------------------------------
  typedef enum logic {
    OFM_CLOCK_GOOD,
    OFM_CLOCK_FAULT
  } ofm_fault_state_t;

endpackage : ofm_pkg

// [design/ofm_window.sv]
/*
  Measurement window: counts the monitored oscillator divided by four over a
  fixed number of reference clock cycles and reports the count once per window.
  Assumes both clock levels are synchronous to clk_i and slower than half its rate.
*/
`timescale 1ns/100ps
`include "ofm_defines.svh"
module ofm_window #(
  parameter int REF_WINDOW = `OFM_REF_WINDOW,
  parameter int TARGET_DIV = `OFM_TARGET_DIV
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  // Clock levels and control
  input  wire logic              ref_level_i,
  input  wire logic              osc_level_i,
  input  wire logic              active_i,
  // Result
  output ofm_pkg::ofm_meas_t     meas_o,
  output logic                   osc_edge_o
);
  import ofm_pkg::*;

  localparam int RW = $clog2(REF_WINDOW);
  localparam int DW = $clog2(TARGET_DIV);

  typedef struct packed {
    logic          ref_prev;
    logic          osc_prev;
    logic [RW-1:0] ref_cnt;
    logic [DW-1:0] div;
    logic [8:0]    cnt;
    ofm_meas_t     meas;
  } ofm_win_state_t;

  ofm_win_state_t s_q, s_d;
  logic ref_rise, osc_rise;

  // The window is fixed in reference edges; the limits absorb the reference spread.
  assign ref_rise   = ref_level_i & ~s_q.ref_prev;
  assign osc_rise   = osc_level_i & ~s_q.osc_prev;
  assign osc_edge_o = osc_rise;
  assign meas_o     = s_q.meas;

  always_comb begin
    s_d           = s_q;
    s_d.ref_prev  = ref_level_i;
    s_d.osc_prev  = osc_level_i;
    s_d.meas.done = 1'b0;
    if (!active_i) begin
      s_d.ref_cnt = '0;
      s_d.div     = '0;
      s_d.cnt     = '0;
    end else begin
      // Target divided by four; the count saturates rather than wrapping.
      if (osc_rise) begin
        s_d.div = s_q.div + DW'(1);
        if (s_q.div == DW'(TARGET_DIV - 1) && s_q.cnt != 9'h1FF) begin
          s_d.cnt = s_q.cnt + 9'h001;
        end
      end
      if (ref_rise) begin
        s_d.ref_cnt = s_q.ref_cnt + RW'(1);
        if (s_q.ref_cnt == RW'(REF_WINDOW - 1)) begin
          // A stopped oscillator ends the window with a count of zero.
          s_d.meas.done  = 1'b1;
          s_d.meas.count = s_q.cnt;
          s_d.cnt        = '0;
          s_d.div        = '0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : ofm_window

// [design/ofm_persist.sv]
/*
  Persistence filter: a fault is declared after a run of bad windows and
  cleared after an equal run of good windows.
  Assumes one result pulse per measurement window.
*/
`timescale 1ns/100ps
`include "ofm_defines.svh"
module ofm_persist #(
  parameter int PERSIST_WINDOWS = `OFM_PERSIST_WINDOWS
) (
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  nrst_i,
  // Window results
  input  wire logic  active_i,
  input  wire logic  done_i,
  input  wire logic  bad_i,
  // Filtered fault
  output logic       fault_o
);
  import ofm_pkg::*;

  localparam int PW = $clog2(PERSIST_WINDOWS + 1);

  typedef struct packed {
    ofm_fault_state_t state;
    logic [PW-1:0]    run;
  } ofm_persist_state_t;

  ofm_persist_state_t s_q, s_d;

  assign fault_o = (s_q.state == OFM_CLOCK_FAULT);

  always_comb begin
    s_d = s_q;
    if (!active_i) begin
      s_d.state = OFM_CLOCK_GOOD;
      s_d.run   = '0;
    end else if (done_i) begin
      case (s_q.state)
        OFM_CLOCK_GOOD: begin
          // One stray window never trips the reset.
          if (!bad_i) begin
            s_d.run = '0;
          end else if (s_q.run == PW'(PERSIST_WINDOWS - 1)) begin
            s_d.state = OFM_CLOCK_FAULT;
            s_d.run   = '0;
          end else begin
            s_d.run = s_q.run + PW'(1);
          end
        end
        OFM_CLOCK_FAULT: begin
          // Release needs an unbroken run of good windows.
          if (bad_i) begin
            s_d.run = '0;
          end else if (s_q.run == PW'(PERSIST_WINDOWS - 1)) begin
            s_d.state = OFM_CLOCK_GOOD;
            s_d.run   = '0;
          end else begin
            s_d.run = s_q.run + PW'(1);
          end
        end
        default: begin
          s_d.state = OFM_CLOCK_GOOD;
          s_d.run   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_q <= '{state: OFM_CLOCK_GOOD, run: '0};
    end else begin
      s_q <= s_d;
    end
  end

endmodule : ofm_persist

// [design/ofm_top.sv]
/*
  Oscillation frequency monitor top: register file with write key, enable
  code and four limit registers, limit pair selection, out-of-range compare
  and the chip reset and pin float outputs.
  Assumes nrst_i carries only the pin, power-on and voltage-detect resets; the
  monitor's own, watchdog and core resets are never routed here. Clock levels
  and mode inputs are synchronous to clk_i.
*/
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`include "ofm_defines.svh"
module ofm_top #(
  parameter int REF_WINDOW      = `OFM_REF_WINDOW,
  parameter int TARGET_DIV      = `OFM_TARGET_DIV,
  parameter int PERSIST_WINDOWS = `OFM_PERSIST_WINDOWS
) (
  // Clock and cold reset
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  // Register port
  input  wire logic [31:0]          addr_i,
  input  wire logic [31:0]          wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [31:0]          rdata_o,
  // Monitored and reference clock levels
  input  wire logic                 osc_level_i,
  input  wire logic                 ref_level_i,
  // Operating mode and clock selection
  input  wire logic                 pll_active_select_i,
  input  wire logic                 stop_mode_i,
  input  wire logic                 warmup_i,
  // Reset outputs
  output logic                      monitor_reset_o,
  output logic                      io_float_o,
  output logic                      core_reset_o
);
  import ofm_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  key;
    logic [7:0]  code;
    logic [8:0]  lower_off;
    logic [8:0]  lower_on;
    logic [8:0]  upper_off;
    logic [8:0]  upper_on;
    logic [31:0] rdata;
    logic [8:0]  last_count;
    logic        low_seen;
    logic        high_seen;
    logic        active;
    logic        mon_rst;
    logic        io_float;
    logic        core_rst;
  } ofm_regs_t;

  ofm_regs_t    r_q, r_d;
  ofm_bus_req_t req;
  ofm_meas_t    meas;
  logic         osc_edge;
  logic         fault;
  logic         check_ok;
  logic [8:0]   lower_sel;
  logic [8:0]   upper_sel;
  logic         too_low;
  logic         too_high;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ------------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------------
  function automatic logic is_limit(input logic [31:0] a);
    is_limit = (a == `OFM_ADDR_LOWER_OFF) || (a == `OFM_ADDR_LOWER_ON) ||
               (a == `OFM_ADDR_UPPER_OFF) || (a == `OFM_ADDR_UPPER_ON);
  endfunction : is_limit

  function automatic logic [31:0] widen9(input logic [8:0] v);
    widen9 = {23'h00_0000, v};
  endfunction : widen9

  // ------------------------------------------------------------------
  // Check enable and compare
  // ------------------------------------------------------------------
  // Checking runs only when enabled and neither in STOP nor its warm-up,
  // so NORMAL and IDLE are the only modes that see it.
  assign check_ok = (r_q.code == `OFM_CODE_ENABLE) && !stop_mode_i && !warmup_i;

  // The pair follows the PLL selection with no software action.
  assign lower_sel = pll_active_select_i ? r_q.lower_on : r_q.lower_off;
  assign upper_sel = pll_active_select_i ? r_q.upper_on : r_q.upper_off;
  assign too_low   = meas.count < lower_sel;
  assign too_high  = meas.count > upper_sel;

  // ------------------------------------------------------------------
  // Measurement and persistence
  // ------------------------------------------------------------------
  ofm_window #(
    .REF_WINDOW (REF_WINDOW),
    .TARGET_DIV (TARGET_DIV)
  ) u_window (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .ref_level_i (ref_level_i),
    .osc_level_i (osc_level_i),
    .active_i    (r_q.active),
    .meas_o      (meas),
    .osc_edge_o  (osc_edge)
  );

  ofm_persist #(
    .PERSIST_WINDOWS (PERSIST_WINDOWS)
  ) u_persist (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .active_i (r_q.active),
    .done_i   (meas.done),
    .bad_i    (too_low | too_high),
    .fault_o  (fault)
  );

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    r_d        = r_q;
    r_d.rdata  = 32'h0000_0000;
    r_d.active = check_ok;

    // Write key: anything but the two codes falls back to locked.
    if (req.wr && req.addr == `OFM_ADDR_WRITE_KEY) begin
      if (req.wdata[7:0] == `OFM_KEY_UNLOCK) begin
        r_d.key = `OFM_KEY_UNLOCK;
      end else begin
        r_d.key = `OFM_KEY_LOCK;
      end
    end

    // Enable code: unlocked, only the two codes are taken.
    if (req.wr && req.addr == `OFM_ADDR_ENABLE_CODE && r_q.key == `OFM_KEY_UNLOCK) begin
      if (req.wdata[7:0] == `OFM_CODE_ENABLE || req.wdata[7:0] == `OFM_CODE_DISABLE) begin
        r_d.code = req.wdata[7:0];
      end
    end

    // Limits change only while unlocked and detection is off; the key and
    // code are judged before this cycle's write, so a key write in the same
    // cycle cannot open the gate early.
    if (req.wr && is_limit(req.addr) && r_q.key == `OFM_KEY_UNLOCK &&
        r_q.code != `OFM_CODE_ENABLE) begin
      case (req.addr)
        `OFM_ADDR_LOWER_OFF: r_d.lower_off = req.wdata[8:0];
        `OFM_ADDR_LOWER_ON:  r_d.lower_on  = req.wdata[8:0];
        `OFM_ADDR_UPPER_OFF: r_d.upper_off = req.wdata[8:0];
        `OFM_ADDR_UPPER_ON:  r_d.upper_on  = req.wdata[8:0];
        default:             r_d.lower_off = r_q.lower_off;
      endcase
    end

    // Reads never depend on the key.
    if (req.rd) begin
      case (req.addr)
        `OFM_ADDR_WRITE_KEY:   r_d.rdata = {24'h00_0000, r_q.key};
        `OFM_ADDR_ENABLE_CODE: r_d.rdata = {24'h00_0000, r_q.code};
        `OFM_ADDR_LOWER_OFF:   r_d.rdata = widen9(r_q.lower_off);
        `OFM_ADDR_LOWER_ON:    r_d.rdata = widen9(r_q.lower_on);
        `OFM_ADDR_UPPER_OFF:   r_d.rdata = widen9(r_q.upper_off);
        `OFM_ADDR_UPPER_ON:    r_d.rdata = widen9(r_q.upper_on);
        `OFM_ADDR_STATUS: begin
          r_d.rdata[`OFM_STATUS_FAULT_BIT]  = r_q.mon_rst;
          r_d.rdata[`OFM_STATUS_ACTIVE_BIT] = r_q.active;
          r_d.rdata[`OFM_STATUS_LOW_BIT]    = r_q.low_seen;
          r_d.rdata[`OFM_STATUS_HIGH_BIT]   = r_q.high_seen;
          r_d.rdata[`OFM_STATUS_COUNT_LSB +: 9] = r_q.last_count;
        end
        default:               r_d.rdata = 32'h0000_0000;
      endcase
    end

    // Latest window result, kept for software to observe.
    if (meas.done && r_q.active) begin
      r_d.last_count = meas.count;
      r_d.low_seen   = too_low;
      r_d.high_seen  = too_high;
    end

    // Chip reset and pin float follow the filtered fault together.
    r_d.mon_rst  = fault;
    r_d.io_float = fault;

    // The core side only moves on a monitored clock edge, so a dead
    // oscillator leaves the core frozen in its last state.
    if (osc_edge) begin
      r_d.core_rst = r_q.mon_rst;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Only the cold reset reaches here, so the monitor's own reset leaves
  // every register and the check running.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      r_q <= '{key:        `OFM_KEY_LOCK,
               code:       `OFM_CODE_DISABLE,
               lower_off:  `OFM_RST_LOWER_OFF,
               lower_on:   `OFM_RST_LOWER_ON,
               upper_off:  `OFM_RST_UPPER_OFF,
               upper_on:   `OFM_RST_UPPER_ON,
               default:    '0};
    end else begin
      r_q <= r_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign rdata_o         = r_q.rdata;
  assign monitor_reset_o = r_q.mon_rst;
  assign io_float_o      = r_q.io_float;
  assign core_reset_o    = r_q.core_rst;

endmodule : ofm_top

// [dv/ofm_top_asserts.sv]
/*
  Checker of the monitor top: register readback, reset timing and pin float.
  Assumes it sees only the ofm_top ports and is attached by the bind below.
*/
`timescale 1ns/100ps
`include "ofm_defines.svh"
module ofm_top_asserts #(
  parameter int REF_WINDOW      = 128,
  parameter int TARGET_DIV      = 4,
  parameter int PERSIST_WINDOWS = 4
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        nrst_i,
  // Register port
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  // Clock levels and modes
  input wire logic        osc_level_i,
  input wire logic        ref_level_i,
  input wire logic        pll_active_select_i,
  input wire logic        stop_mode_i,
  input wire logic        warmup_i,
  // Reset outputs
  input wire logic        monitor_reset_o,
  input wire logic        io_float_o,
  input wire logic        core_reset_o
);
  import ofm_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Reference edges are at least two clocks apart; slack covers the pipeline.
  localparam int MIN_RUN = PERSIST_WINDOWS * REF_WINDOW * 2 - 4;
  logic [7:0]  key_q;
  logic [7:0]  code_q;
  logic [15:0] run_q;
  logic [15:0] high_q;
  logic        act;
  logic        lim_rd;
  assign act = code_q == `OFM_CODE_ENABLE && !stop_mode_i && !warmup_i;
  assign lim_rd = rd_i && addr_i >= `OFM_ADDR_LOWER_OFF && addr_i <= `OFM_ADDR_UPPER_ON;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      key_q  <= `OFM_KEY_LOCK;
      code_q <= `OFM_CODE_DISABLE;
      run_q  <= '0;
      high_q <= '0;
    end else begin
      if (wr_i && addr_i == `OFM_ADDR_WRITE_KEY)
        key_q <= (wdata_i[7:0] == `OFM_KEY_UNLOCK) ? `OFM_KEY_UNLOCK : `OFM_KEY_LOCK;
      if (wr_i && addr_i == `OFM_ADDR_ENABLE_CODE && key_q == `OFM_KEY_UNLOCK &&
          (wdata_i[7:0] == `OFM_CODE_ENABLE || wdata_i[7:0] == `OFM_CODE_DISABLE))
        code_q <= wdata_i[7:0];
      run_q  <= !act ? '0 : run_q + 16'(run_q != 16'hFFFF);
      high_q <= !monitor_reset_o ? '0 : high_q + 16'(high_q != 16'hFFFF);
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_float_tracks_reset: assert property (io_float_o == monitor_reset_o)
    else $error("io float differs from monitor reset");
  a_key_readback: assert property (
    rd_i && addr_i == `OFM_ADDR_WRITE_KEY |=> rdata_o == 32'(key_q))
    else $error("write key read back wrong");
  a_code_readback: assert property (
    rd_i && addr_i == `OFM_ADDR_ENABLE_CODE |=> rdata_o == 32'(code_q))
    else $error("enable code read back wrong");
  a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data outside the answer cycle");
  a_limit_upper_zero: assert property (lim_rd |=> rdata_o[31:9] == '0)
    else $error("limit upper bits not zero");
  a_inactive_quiet: assert property ((!act) [*5] |-> !monitor_reset_o)
    else $error("monitor reset while detection inactive");
  a_rise_needs_run: assert property (
    $rose(monitor_reset_o) |-> run_q >= 16'(MIN_RUN))
    else $error("monitor reset before persistence run");
  a_fall_needs_good: assert property (
    $fell(monitor_reset_o) |-> high_q >= 16'(MIN_RUN) || !$past(act))
    else $error("monitor reset released too early");
  a_core_holds: assert property (
    $stable(osc_level_i) [*4] |-> $stable(core_reset_o))
    else $error("core reset moved without oscillator edge");
  c_fault_raised: cover property ($rose(monitor_reset_o));
  c_fault_cleared: cover property ($fell(monitor_reset_o) && act);
  c_core_latched: cover property ($rose(core_reset_o));
endmodule : ofm_top_asserts

bind ofm_top ofm_top_asserts #(
  .REF_WINDOW(REF_WINDOW), .TARGET_DIV(TARGET_DIV), .PERSIST_WINDOWS(PERSIST_WINDOWS)
) ofm_top_asserts_i (
  .clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .osc_level_i,
  .ref_level_i, .pll_active_select_i, .stop_mode_i, .warmup_i, .monitor_reset_o,
  .io_float_o, .core_reset_o
);

// [dv/ofm_clock_model.sv]
/*
  Model of the monitored oscillator and the reference clock as sampled levels.
  Assumes clk_i is the system clock; both levels change just after its edge.
*/
`timescale 1ns/100ps
module ofm_clock_model #(
  parameter int REF_HALF = 4
) (
  // Clock and oscillator control
  input  wire logic clk_i,
  input  wire logic run_i,
  // Levels
  output logic      osc_level_o,
  output logic      ref_level_o
);
  int cnt_q;
  initial begin
    cnt_q = 0;
    osc_level_o = 1'b0;
    ref_level_o = 1'b0;
  end
  always @(posedge clk_i) begin
    cnt_q <= (cnt_q == REF_HALF - 1) ? 0 : cnt_q + 1;
    if (cnt_q == REF_HALF - 1)
      ref_level_o <= !ref_level_o;
    // A stopped oscillator holds its level, so no edges reach the counter.
    if (run_i)
      osc_level_o <= !osc_level_o;
  end
endmodule : ofm_clock_model

// [dv/ofm_top_tb_top.sv]
/*
  Self-checking bench of the monitor top with a clock level model.
  Assumes a window of 8 reference edges (64 clocks) and two-window persistence.
*/
`timescale 1ns/100ps
`include "ofm_defines.svh"
module ofm_top_tb_top;
  import ofm_pkg::*;
  localparam logic [31:0] A_KEY  = `OFM_ADDR_WRITE_KEY;
  localparam logic [31:0] A_CODE = `OFM_ADDR_ENABLE_CODE;
  localparam logic [31:0] LA [4] = '{`OFM_ADDR_LOWER_OFF, `OFM_ADDR_LOWER_ON,
                                     `OFM_ADDR_UPPER_OFF, `OFM_ADDR_UPPER_ON};
  localparam logic [31:0] LR [4] = '{32'h0000_0010, 32'h0000_00D1,
                                     32'h0000_0028, 32'h0000_0139};
  logic        clk_i, nrst_i, wr_i, rd_i, run, osc_level_i, ref_level_i;
  logic        pll_active_select_i, stop_mode_i, warmup_i;
  logic        monitor_reset_o, io_float_o, core_reset_o;
  logic [31:0] addr_i, wdata_i, rdata_o;
  int          n_errors, tests_run;
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  ofm_clock_model ofm_clock_model_i (.clk_i, .run_i(run), .osc_level_o(osc_level_i),
                                     .ref_level_o(ref_level_i));
  ofm_top #(.REF_WINDOW(8), .TARGET_DIV(4), .PERSIST_WINDOWS(2)) ofm_top_i (
    .clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .osc_level_i,
    .ref_level_i, .pll_active_select_i, .stop_mode_i, .warmup_i, .monitor_reset_o,
    .io_float_o, .core_reset_o);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task rd_chk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rd_chk
  task set_code(input logic [7:0] c);
    wr(A_KEY, 32'h0000_00F9);
    wr(A_CODE, 32'(c));
    wr(A_KEY, 32'h0000_0006);
  endtask : set_code
  task wait_mon(input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk_i);
      #1;
      if (monitor_reset_o === v) break;
    end
    chk(32'(monitor_reset_o), 32'(v));
  endtask : wait_mon
  task hold_mon(input logic v, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1 bad += (monitor_reset_o !== v);
    end
    chk(bad, 0);
  endtask : hold_mon
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    rd_chk(A_KEY, 32'h0000_0006);
    rd_chk(A_CODE, 32'h0000_0000);
    for (int i = 0; i < 4; i++) rd_chk(LA[i], LR[i]);
    rd_chk(32'h4004_0900, 32'h0000_0000);
    wr(LA[0], 32'h0000_0055);
    rd_chk(LA[0], LR[0]);
    wr(A_KEY, 32'h0000_0012);
    rd_chk(A_KEY, 32'h0000_0006);
    wr(A_KEY, 32'h0000_00F9);
    rd_chk(A_KEY, 32'h0000_00F9);
    wr(LA[0], 32'hFFFF_FE04);
    rd_chk(LA[0], 32'h0000_0004);
    // Eight counts per window sit inside 4..12 but above the 1..2 pair.
    wr(LA[1], 32'h0000_0001);
    wr(LA[2], 32'h0000_000C);
    wr(LA[3], 32'h0000_0002);
    wr(A_CODE, 32'h0000_0033);
    rd_chk(A_CODE, 32'h0000_0000);
    wr(A_CODE, 32'h0000_00E4);
    rd_chk(A_CODE, 32'h0000_00E4);
    wr(LA[3], 32'h0000_01FF);
    rd_chk(LA[3], 32'h0000_0002);
    wr(A_CODE, 32'h0000_0000);
    wr(A_KEY, 32'h0000_0006);
    rd_chk(LA[2], 32'h0000_000C);
    $display("t_regs done");
  endtask : t_regs
  task t_pair;
    set_code(8'hE4);
    hold_mon(1'b0, 400);
    set_code(8'h00);
    pll_active_select_i <= 1'b1;
    set_code(8'hE4);
    hold_mon(1'b0, 100);
    wait_mon(1'b1, 400);
    chk(32'(io_float_o), 32'h0000_0001);
    set_code(8'h00);
    wait_mon(1'b0, 10);
    @(posedge clk_i);
    pll_active_select_i <= 1'b0;
    $display("t_pair done");
  endtask : t_pair
  task t_osc_stop;
    set_code(8'hE4);
    run <= 1'b0;
    wait_mon(1'b1, 400);
    chk(32'(core_reset_o), 32'h0000_0000);
    rd_chk(`OFM_ADDR_STATUS, 32'h0000_0007);
    run <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1 chk(32'(core_reset_o), 32'h0000_0001);
    hold_mon(1'b1, 100);
    wait_mon(1'b0, 400);
    $display("t_osc_stop done");
  endtask : t_osc_stop
  task t_stop_mode;
    run <= 1'b0;
    wait_mon(1'b1, 400);
    @(posedge clk_i);
    stop_mode_i <= 1'b1;
    wait_mon(1'b0, 8);
    hold_mon(1'b0, 300);
    @(posedge clk_i);
    stop_mode_i <= 1'b0;
    warmup_i <= 1'b1;
    hold_mon(1'b0, 100);
    @(posedge clk_i);
    warmup_i <= 1'b0;
    wait_mon(1'b1, 400);
    $display("t_stop_mode done");
  endtask : t_stop_mode
  task t_cold;
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1 chk(32'(monitor_reset_o), 32'h0000_0000);
    rd_chk(A_CODE, 32'h0000_0000);
    rd_chk(A_KEY, 32'h0000_0006);
    rd_chk(LA[0], LR[0]);
    hold_mon(1'b0, 300);
    $display("t_cold done");
  endtask : t_cold
  task end_sim;
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  initial begin
    n_errors = 0;
    tests_run = 0;
    {nrst_i, wr_i, rd_i, pll_active_select_i, stop_mode_i, warmup_i} = '0;
    run = 1'b1;
    addr_i = '0;
    wdata_i = '0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_pair();
    t_osc_stop();
    t_stop_mode();
    t_cold();
    end_sim();
  end
  // The whole sequence needs under 3500 clocks; the limit leaves ample room.
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    $display("watchdog expired");
    end_sim();
  end
endmodule : ofm_top_tb_top
